// file: rtl/prog_link_ctrl.sv
// Controller end: builds Manchester frames on the supply line at a set rate.
`timescale 1ns/1ps
`default_nettype none
module prog_link_ctrl #(
   parameter int HALF_CYC = 100
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Link side.
   prog_link_if.ctrl link,
   // User side.
   input wire logic send_in,
   input wire logic read_in,
   input wire logic [prog_link_pkg::ADDR_W-1:0] addr_in,
   input wire logic [prog_link_pkg::DATA_W-1:0] data_in,
   output logic busy_out
);
   import prog_link_pkg::*;

   logic [FRAME_MAX-1:0] sh_q;
   logic [5:0] n_q;
   logic [CNT_W-1:0] c_q;
   logic hs_q, pin_q;
   // Frame CRC over direction, address and optional data.
   function automatic logic [2:0] crc_bits(input logic [FRAME_MAX-1:0] s, input int n);
      logic [2:0] c;
      c = CRC_PRESET;
      for (int i = FRAME_MAX - 1; i >= 0; i--) begin
         if (i < n) begin
            c = crc_step(c, s[i]);
         end
      end
      crc_bits = c;
   endfunction : crc_bits
   wire [36:0] body = {1'b0, addr_in, data_in};
   wire [FRAME_MAX-1:0] wr_f = {2'b00, body, crc_bits({5'h0, body}, 37)};
   wire [6:0] rbody = {1'b1, addr_in};
   wire [FRAME_MAX-1:0] rd_f = {2'b00, rbody, crc_bits({35'h0, rbody}, 7), 30'h0};
   // Shifts one bit per cell, first half the bit, second half its inverse.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         sh_q <= '0;
         n_q <= '0;
         c_q <= '0;
         hs_q <= 1'b0;
         pin_q <= 1'b1;
      end else if (n_q == '0) begin
         pin_q <= 1'b1;
         if (send_in) begin
            sh_q <= read_in ? rd_f : wr_f;
            n_q <= read_in ? SHORT_LEN : LONG_LEN;
            c_q <= '0;
            hs_q <= 1'b0;
         end
      end else begin
         pin_q <= hs_q ? !sh_q[FRAME_MAX-1] : sh_q[FRAME_MAX-1];
         if (c_q == HALF_CYC[CNT_W-1:0] - 16'h1) begin
            c_q <= '0;
            hs_q <= !hs_q;
            if (hs_q) begin
               sh_q <= sh_q << 1;
               n_q <= n_q - 6'd1;
            end
         end else begin
            c_q <= c_q + 16'h1;
         end
      end
   end
   logic busy_q;
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (n_q != '0) || send_in;
      end
   end
   assign link.supply_mod = pin_q;
   assign busy_out = busy_q;
endmodule : prog_link_ctrl
`default_nettype wire

// file: rtl/prog_link_device.sv
// Device end of the Manchester programming link: receive, decode, answer reads.
`timescale 1ns/1ps
`default_nettype none
module prog_link_device #(
   parameter int WORDS = 32,
   parameter bit ECC_ON = 1'b1,
   parameter int ACC_TIMEOUT_CYC = 1_400_000
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Link side.
   prog_link_if.device link,
   // User side.
   input wire logic normal_level_in,
   output logic access_granted_out,
   output logic out_disabled_out,
   output logic frame_error_out,
   output logic wr_valid_out,
   output logic [prog_link_pkg::ADDR_W-1:0] wr_addr_out,
   output logic [prog_link_pkg::DATA_W-1:0] wr_data_out
);
   import prog_link_pkg::*;

   // Supply input synchroniser; the first stage feeds only the second.
   logic s1_q, s2_q, s3_q, lvl_q;
   always_ff @(posedge clk_in) begin
      s1_q <= link.supply_mod;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end
   wire agree = (s2_q == s3_q);
   // Filtered level changes only once two stages agree.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         lvl_q <= 1'b1;
      end else if (agree) begin
         lvl_q <= s3_q;
      end
   end
   wire edge_seen = agree && (s3_q != lvl_q);
   wire rising = edge_seen && s3_q;

   // Receive state: cell timing is learned from the two sync bits.
   logic [CNT_W-1:0] tcnt_q, half_q;
   logic [5:0] nbits_q;
   logic [FRAME_MAX-1:0] shift_q;
   logic busy_q, have_half_q;
   wire [CNT_W-1:0] tcnt_inc = tcnt_q + 16'h1;
   // A mid-cell edge arrives past three quarters of a cell since the last one.
   wire [CNT_W-1:0] gate = half_q + (half_q >> 1);
   wire mid_edge = edge_seen && busy_q && have_half_q && (tcnt_q >= gate);
   wire timeout = busy_q && (tcnt_q >= IDLE_CYC[CNT_W-1:0]);

   // Frame fields, sync stripped, MSB first.
   wire [5:0] len = nbits_q;
   wire is_read = shift_q[SHORT_LEN-3] && (len == SHORT_LEN);
   wire is_write = !shift_q[LONG_LEN-3] && (len == LONG_LEN);
   wire [ADDR_W-1:0] f_addr = is_read ? shift_q[8:3] : shift_q[38:33];
   wire [DATA_W-1:0] f_data = shift_q[32:3];
   wire [CRC_W-1:0] f_crc = shift_q[2:0];

   // CRC over the direction, address and data bits.
   function automatic logic [2:0] crc_frame(input logic [FRAME_MAX-1:0] s, input logic [5:0] n);
      logic [2:0] c;
      c = CRC_PRESET;
      for (int i = FRAME_MAX - 1; i >= 0; i--) begin
         if (i < n && i >= 3 && i < n - 2) begin
            c = crc_step(c, s[i]);
         end
      end
      crc_frame = c;
   endfunction : crc_frame
   wire crc_ok = (crc_frame(shift_q, len) == f_crc);
   wire sync_ok = (shift_q[len-1] == 1'b0) && (shift_q[len-2] == 1'b0);

   // Decoder: measures one full cell across the sync bits, halves it, then samples each mid-cell edge.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         busy_q <= 1'b0;
         have_half_q <= 1'b0;
         tcnt_q <= '0;
         half_q <= '0;
         nbits_q <= '0;
         shift_q <= '0;
      end else if (!busy_q) begin
         // Idle: first rising edge is the mid-cell of sync bit zero.
         tcnt_q <= '0;
         if (rising) begin
            busy_q <= 1'b1;
            have_half_q <= 1'b0;
            nbits_q <= 6'd1;
            shift_q <= '0;
         end
      end else if (timeout) begin
         busy_q <= 1'b0;
      end else if (edge_seen && !have_half_q) begin
         // Second sync bit: boundary edge then mid edge; measure one full cell.
         if (rising) begin
            half_q <= tcnt_inc >> 1;
            have_half_q <= 1'b1;
            nbits_q <= 6'd2;
            tcnt_q <= '0;
         end else begin
            tcnt_q <= tcnt_inc;
         end
      end else if (mid_edge) begin
         shift_q <= {shift_q[FRAME_MAX-2:0], !s3_q};
         nbits_q <= nbits_q + 6'd1;
         tcnt_q <= '0;
      end else begin
         tcnt_q <= tcnt_inc;
      end
   end
   wire frame_end = timeout;

   // Command handling and access state.
   logic [DATA_W-1:0] mem_q [WORDS];
   logic granted_q, code_seen_q, dis_q, err_q, wv_q;
   logic [ADDR_W-1:0] wa_q, ra_q;
   logic [DATA_W-1:0] wd_q;
   logic [21:0] age_q;
   logic ack_req_q;
   wire good = frame_end && crc_ok && sync_ok && (is_read || is_write);
   wire is_ctrl = (f_addr == CTRL_REG_ADDR);
   wire in_window = (age_q < ACC_TIMEOUT_CYC[21:0]);
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         granted_q <= 1'b0;
         code_seen_q <= 1'b0;
         dis_q <= 1'b0;
         err_q <= 1'b0;
         wv_q <= 1'b0;
         wa_q <= '0;
         wd_q <= '0;
         ra_q <= '0;
         ack_req_q <= 1'b0;
         age_q <= '0;
      end else begin
         wv_q <= 1'b0;
         ack_req_q <= 1'b0;
         err_q <= frame_end && !good;
         if (in_window) begin
            age_q <= age_q + 22'h1;
         end
         if (good && is_write && is_ctrl && !code_seen_q) begin
            code_seen_q <= 1'b1;
            granted_q <= in_window && (f_data == ACCESS_CODE);
         end else if (good && granted_q && is_write && is_ctrl) begin
            if (f_data == OUT_DISABLE_DATA) begin
               dis_q <= 1'b1;
            end else if (f_data == OUT_ENABLE_DATA) begin
               dis_q <= 1'b0;
            end
         end else if (good && granted_q && is_write && !f_addr[ADDR_W-1] && dis_q) begin
            wv_q <= 1'b1;
            wa_q <= f_addr;
            wd_q <= f_data;
         end else if (good && granted_q && is_read && dis_q) begin
            ra_q <= f_addr;
            ack_req_q <= 1'b1;
         end
      end
   end

   // Non-volatile word store; ECC builds check bits into the top six.
   always_ff @(posedge clk_in) begin
      if (wv_q && int'(wa_q) < WORDS) begin
         mem_q[wa_q[4:0]] <= wd_q;
      end
   end
   wire [DATA_W-1:0] rd_word = (ra_q[ADDR_W-1] || int'(ra_q) >= WORDS) ? '0 : mem_q[ra_q[4:0]];
   wire [5:0] chk = {^rd_word[23:18], ^rd_word[17:12], ^rd_word[11:6], ^rd_word[5:0],
                     ^rd_word[23:12], ^rd_word[11:0]};
   wire [DATA_W-1:0] ack_word = ECC_ON ? {chk, rd_word[23:0]} : rd_word;

   // Acknowledge transmitter: sync, 30 data, CRC, at the learned rate.
   localparam int ACK_LEN = SYNC_BITS + DATA_W + CRC_W;
   logic [ACK_LEN-1:0] tx_q;
   logic [5:0] txn_q;
   logic [CNT_W-1:0] txc_q, dly_q;
   logic half_sel_q, tx_pin_q, waiting_q;
   function automatic logic [2:0] crc_word(input logic [DATA_W-1:0] d);
      logic [2:0] c;
      c = CRC_PRESET;
      for (int i = DATA_W - 1; i >= 0; i--) begin
         c = crc_step(c, d[i]);
      end
      crc_word = c;
   endfunction : crc_word
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         tx_q <= '0;
         txn_q <= '0;
         txc_q <= '0;
         dly_q <= '0;
         half_sel_q <= 1'b0;
         tx_pin_q <= 1'b1;
         waiting_q <= 1'b0;
      end else if (ack_req_q) begin
         waiting_q <= 1'b1;
         dly_q <= READ_DELAY_CYC[CNT_W-1:0];
         tx_q <= {2'b00, ack_word, crc_word(ack_word)};
      end else if (waiting_q) begin
         dly_q <= dly_q - 16'h1;
         if (dly_q == '0) begin
            waiting_q <= 1'b0;
            txn_q <= ACK_LEN[5:0];
            txc_q <= '0;
            half_sel_q <= 1'b0;
         end
      end else if (txn_q != '0) begin
         // First half carries the bit, second half its inverse; each half lasts half_q cycles.
         tx_pin_q <= half_sel_q ? !tx_q[ACK_LEN-1] : tx_q[ACK_LEN-1];
         if (txc_q + 16'h1 >= half_q) begin
            txc_q <= '0;
            half_sel_q <= !half_sel_q;
            if (half_sel_q) begin
               tx_q <= tx_q << 1;
               txn_q <= txn_q - 6'd1;
            end
         end else begin
            txc_q <= txc_q + 16'h1;
         end
      end else begin
         tx_pin_q <= 1'b1;
      end
   end

   // Output pin: normal level, released, or acknowledge drive.
   logic oe_q, o_q;
   wire sending = (txn_q != '0);
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         oe_q <= 1'b1;
         o_q <= 1'b0;
      end else begin
         oe_q <= !dis_q || sending;
         o_q <= sending ? tx_pin_q : normal_level_in;
      end
   end
   assign link.sensor_output_pin_oe = oe_q;
   assign link.sensor_output_pin_o = o_q;
   assign access_granted_out = granted_q;
   assign out_disabled_out = dis_q;
   assign frame_error_out = err_q;
   assign wr_valid_out = wv_q;
   assign wr_addr_out = wa_q;
   assign wr_data_out = wd_q;
endmodule : prog_link_device
`default_nettype wire

// file: rtl/prog_link_if.sv
// Interface joining the supply-line and output-line of the programming link.
`timescale 1ns/1ps
`default_nettype none
interface prog_link_if;
   logic supply_mod;       // Modulated supply level driven by the controller.
   logic sensor_output_pin_o;  // Device drive level on the output pin.
   logic sensor_output_pin_oe; // Device drives the output pin when high.
   logic sensor_output_pin;    // Resolved output pin level.
   assign sensor_output_pin = sensor_output_pin_oe ? sensor_output_pin_o : 1'b1;
   modport device (input supply_mod, sensor_output_pin, output sensor_output_pin_o,
                   output sensor_output_pin_oe);
   modport ctrl (output supply_mod, input sensor_output_pin, sensor_output_pin_o,
                 sensor_output_pin_oe);
endinterface : prog_link_if
`default_nettype wire

// file: rtl/prog_link_pkg.sv
// Shared constants for the Manchester programming link.
package prog_link_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 30;
   localparam int CRC_W = 3;
   localparam int SYNC_BITS = 2;
   localparam logic [2:0] CRC_PRESET = 3'h7;
   localparam logic [2:0] CRC_POLY = 3'h3;
   localparam logic [5:0] CTRL_REG_ADDR = 6'h24;
   localparam logic [29:0] ACCESS_CODE = 30'h27811F77;
   localparam logic [29:0] OUT_DISABLE_DATA = 30'h10;
   localparam logic [29:0] OUT_ENABLE_DATA = 30'h0;
   localparam int CLK_HZ = 20_000_000;
   localparam int MIN_BAUD = 5_000;
   localparam int MAX_BAUD = 100_000;
   // Longest half bit at the slowest rate, in cycles, with no margin.
   localparam int HALF_MAX_CYC = CLK_HZ / MIN_BAUD / 2;
   localparam int IDLE_CYC = HALF_MAX_CYC * 3;
   localparam int CNT_W = 16;
   localparam int READ_DELAY_US = 50;
   localparam int READ_DELAY_CYC = (READ_DELAY_US * (CLK_HZ / 1_000_000));
   localparam int FRAME_MAX = SYNC_BITS + 1 + ADDR_W + DATA_W + CRC_W;
   localparam logic [5:0] SHORT_LEN = 6'd12;
   localparam logic [5:0] LONG_LEN = 6'd42;
   // Advances a CRC of x^3+x+1 by one bit.
   function automatic logic [2:0] crc_step(input logic [2:0] c, input logic b);
      logic fb;
      fb = c[2] ^ b;
      crc_step = {c[1], c[0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
   endfunction : crc_step
endpackage : prog_link_pkg

// file: testbench/prog_link_properties.sv
// Concurrent checks on the wires between the controller and device ends.
`timescale 1ns/1ps
`default_nettype none
module prog_link_properties
   import prog_link_pkg::*;
(
   // Clock and reset.
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Link wires.
   input wire logic supply_mod,
   input wire logic sensor_output_pin_o,
   input wire logic sensor_output_pin_oe,
   input wire logic sensor_output_pin
);
   logic [15:0] sup_cnt_q; // Cycles since the supply line last moved.
   logic [15:0] pin_cnt_q; // Cycles since the output pin last moved.
   logic sup_prev_q; // Supply level at the previous edge.
   logic pin_prev_q; // Pin level at the previous edge.
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // Run lengths saturate, so a long idle gap stays recognisable.
   always_ff @(posedge clk_in) begin
      sup_prev_q <= supply_mod;
      pin_prev_q <= sensor_output_pin;
      if (!reset_n_in) sup_cnt_q <= 16'hFFFF;
      else if (supply_mod != sup_prev_q) sup_cnt_q <= 16'h0000;
      else if (sup_cnt_q != 16'hFFFF) sup_cnt_q <= sup_cnt_q + 16'h0001;
      if (!reset_n_in) pin_cnt_q <= 16'hFFFF;
      else if (sensor_output_pin != pin_prev_q) pin_cnt_q <= 16'h0000;
      else if (pin_cnt_q != 16'hFFFF) pin_cnt_q <= pin_cnt_q + 16'h0001;
   end
   // Two zero bits from idle high: low, high, low in half-cell steps of 100 cycles.
   sequence sync_zeros(s);
      ##99 !s ##1 s ##99 s ##1 !s;
   endsequence
   a_reset_drives_pin: assert property (
      $rose(reset_n_in) |-> sensor_output_pin_oe && !sensor_output_pin_o)
      else $error("device does not drive the pin after reset");
   a_supply_idles_high: assert property ($rose(reset_n_in) |-> supply_mod)
      else $error("supply line not idle high after reset");
   a_released_pin_quiet: assert property (
      !sensor_output_pin_oe && !$past(sensor_output_pin_oe) |-> $stable(sensor_output_pin_o))
      else $error("device drive level moves while the pin is released");
   a_supply_half_cell: assert property (
      $changed(supply_mod) && sup_cnt_q < 16'h03E8 |-> sup_cnt_q inside {16'h0063, 16'h00C7})
      else $error("supply run length not one or two half cells");
   a_supply_sync_bits: assert property (
      $fell(supply_mod) && sup_cnt_q >= 16'h03E8 |-> sync_zeros(supply_mod))
      else $error("command frame does not open with two zero bits");
   // An acknowledge starts with a fall while the device already drives the pin.
   a_ack_sync_bits: assert property (
      $fell(sensor_output_pin) && sensor_output_pin_oe && $past(sensor_output_pin_oe)
      && pin_cnt_q >= 16'h03E8
      |-> sync_zeros(sensor_output_pin))
      else $error("acknowledge does not open with two zero bits");
   // The supply last moves at the final mid-cell edge or one half cell later.
   a_release_timing: assert property (
      $changed(sensor_output_pin_oe) && sup_cnt_q < IDLE_CYC + 500
      |-> sup_cnt_q >= IDLE_CYC - 100 && sup_cnt_q <= IDLE_CYC + 400)
      else $error("pin enable changed away from frame end");
   a_ack_read_delay: assert property (
      $fell(sensor_output_pin) && sensor_output_pin_oe && $past(sensor_output_pin_oe)
      && pin_cnt_q >= 16'h03E8
      |-> sup_cnt_q >= IDLE_CYC + READ_DELAY_CYC - 100
      && sup_cnt_q <= IDLE_CYC + READ_DELAY_CYC + 150)
      else $error("acknowledge start off its delay");
endmodule : prog_link_properties
`default_nettype wire

// file: testbench/tb_manchester_program_link.sv
// Self-checking bench: both link ends joined, plus a rogue frame driver on a second device.
`timescale 1ns/1ps
`default_nettype none
module tb_manchester_program_link;
   import prog_link_pkg::*;
   localparam int HALF = 100; // Half bit cell: 100 kbps at 20 MHz.
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic normal_level = 1'b0;
   logic send = 1'b0;
   logic rd = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [29:0] data = 30'h0;
   logic busy, granted, disabled, ferr, wr_valid, granted2, disabled2, ferr2;
   logic [5:0] wr_addr;
   logic [29:0] wr_data;
   int miscompares = 0;
   int n_compared = 0;
   int wr_seen = 0;
   int ferr_seen = 0;
   prog_link_if lk();
   prog_link_if lk2();
   prog_link_device #(.ACC_TIMEOUT_CYC(30000), .ECC_ON(1'b0)) u_prog_link_device (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .link(lk), .normal_level_in(normal_level),
      .access_granted_out(granted), .out_disabled_out(disabled), .frame_error_out(ferr),
      .wr_valid_out(wr_valid), .wr_addr_out(wr_addr), .wr_data_out(wr_data));
   prog_link_ctrl #(.HALF_CYC(HALF)) u_prog_link_ctrl (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .link(lk), .send_in(send), .read_in(rd),
      .addr_in(addr), .data_in(data), .busy_out(busy));
   prog_link_properties u_prog_link_properties (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .supply_mod(lk.supply_mod),
      .sensor_output_pin_o(lk.sensor_output_pin_o),
      .sensor_output_pin_oe(lk.sensor_output_pin_oe), .sensor_output_pin(lk.sensor_output_pin));
   // Second device, fed only by the rogue driver below.
   prog_link_device #(.ACC_TIMEOUT_CYC(30000), .ECC_ON(1'b0)) u_prog_link_device2 (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .link(lk2), .normal_level_in(normal_level),
      .access_granted_out(granted2), .out_disabled_out(disabled2), .frame_error_out(ferr2),
      .wr_valid_out(), .wr_addr_out(), .wr_data_out());
   always #25 clk_in = ~clk_in;
   // Counts write pulses from the first device and frame-error pulses from both devices.
   always @(posedge clk_in) begin
      if (wr_valid === 1'b1) wr_seen++;
      if (ferr2 === 1'b1 || ferr === 1'b1) ferr_seen++;
   end
   task automatic chk(input bit ok, input string msg);
      n_compared++;
      if (!ok) begin
         miscompares++;
         $display("wrong value at %0t ns: %s", $time, msg);
      end
   endtask : chk
   // Expected CRC, preset all ones, over the low n bits taken most significant first.
   function automatic logic [2:0] exp_crc(input logic [38:0] v, input int n);
      logic [2:0] c;
      c = 3'h7;
      for (int i = n - 1; i >= 0; i--) c = {c[1:0], 1'b0} ^ ((c[2] ^ v[i]) ? 3'h3 : 3'h0);
      return c;
   endfunction : exp_crc
   // One command through the controller end; writes also wait out the device decode.
   task automatic send_cmd(input logic r, input logic [5:0] a, input logic [29:0] d);
      @(posedge clk_in);
      send <= 1'b1;
      rd <= r;
      addr <= a;
      data <= d;
      @(posedge clk_in);
      send <= 1'b0;
      @(posedge clk_in);
      for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge clk_in);
      if (!r) repeat (IDLE_CYC + 500) @(posedge clk_in);
   endtask : send_cmd
   // Rogue bit: value in the first half, inverse in the second, so a zero rises mid-cell.
   task automatic man_bit(input logic b);
      lk2.supply_mod <= b;
      repeat (HALF) @(posedge clk_in);
      lk2.supply_mod <= ~b;
      repeat (HALF) @(posedge clk_in);
   endtask : man_bit
   task automatic raw_write(input logic [5:0] a, input logic [29:0] d, input logic [2:0] flip);
      logic [36:0] v;
      logic [2:0] c;
      v = {1'b0, a, d};
      c = exp_crc({2'b00, v}, 37) ^ flip;
      man_bit(1'b0);
      man_bit(1'b0);
      for (int i = 36; i >= 0; i--) man_bit(v[i]);
      for (int i = 2; i >= 0; i--) man_bit(c[i]);
      lk2.supply_mod <= 1'b1;
      repeat (IDLE_CYC + 500) @(posedge clk_in);
   endtask : raw_write
   // Samples the acknowledge mid first half of each of its 35 bits, where the bit stands.
   task automatic get_ack(output logic [34:0] f);
      for (int i = 0; i < 20000 && lk.sensor_output_pin !== 1'b0; i++) @(posedge clk_in);
      repeat (HALF / 2) @(posedge clk_in);
      for (int k = 34; k >= 0; k--) begin
         f[k] = lk.sensor_output_pin;
         if (k > 0) repeat (2 * HALF) @(posedge clk_in);
      end
   endtask : get_ack
   task automatic conclude;
      $display("compared %0d, wrong %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   // The tests take about 77000 cycles.
   initial begin
      repeat (95000) @(posedge clk_in);
      miscompares++;
      conclude();
   end
   initial begin
      logic [5:0] a;
      logic [29:0] d;
      logic [34:0] f;
      int w;
      lk2.supply_mod = 1'b1;
      w = $urandom(96);
      repeat (20) @(posedge clk_in);
      reset_n_in <= 1'b1;
      normal_level <= 1'($urandom);
      fork
         begin
            repeat (3) @(posedge clk_in);
            chk(lk.sensor_output_pin === normal_level, "pin not normal output");
            send_cmd(1'b0, CTRL_REG_ADDR, ACCESS_CODE);
            chk(granted === 1'b1, "access not granted");
            send_cmd(1'b0, CTRL_REG_ADDR, OUT_DISABLE_DATA);
            chk(disabled === 1'b1 && lk.sensor_output_pin_oe === 1'b0, "not released");
            a = {1'b0, 5'($urandom)};
            d = 30'($urandom);
            w = wr_seen;
            send_cmd(1'b0, a, d);
            chk(wr_seen == w + 1 && wr_addr === a && wr_data === d, "write lost");
            send_cmd(1'b1, a, 30'h0);
            get_ack(f);
            chk(f[34:33] === 2'b00, "ack sync bits");
            chk(f[32:3] === d, "ack data");
            chk(f[2:0] === exp_crc({9'h000, d}, 30), "ack crc");
            repeat (8 * HALF) @(posedge clk_in);
            send_cmd(1'b0, CTRL_REG_ADDR, OUT_ENABLE_DATA);
            chk(disabled === 1'b0 && lk.sensor_output_pin_oe === 1'b1, "not enabled");
         end
         begin
            @(posedge clk_in);
            raw_write(CTRL_REG_ADDR, ACCESS_CODE, 3'h1);
            chk(ferr_seen == 1 && granted2 === 1'b0, "bad crc accepted");
            raw_write(CTRL_REG_ADDR, ACCESS_CODE ^ 30'($urandom | 32'h1), 3'h0);
            chk(granted2 === 1'b0 && ferr_seen == 1, "wrong code granted");
            raw_write(CTRL_REG_ADDR, OUT_DISABLE_DATA, 3'h0);
            chk(disabled2 === 1'b0, "command obeyed without access");
         end
      join
      chk(ferr_seen == 1, "stray frame error");
      conclude();
   end
endmodule : tb_manchester_program_link
`default_nettype wire
